//--- bench/sdinit_mem_model.sv
// Behavioural memory device on chip select 0
`timescale 1ns/1ps
module sdinit_mem_model
    import sdinit_pkg::*;
(
    input wire logic hclk,
    input sdinit_cmd_t mem_cmd,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0] domain_chip_select_n,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_wdata_oe,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [256]; // Words by column
    logic [7:0] beat_a [8]; // Burst beat columns
    logic [7:0] beat_v = 8'h0; // Burst beat valid
    logic [2:0] cas_q = 3'h2; // Latency of last mode load
    logic [31:0] idle_q = 32'h0; // Changes off the burst
    // Outside a burst the bus shows a changing pattern
    assign mem_rdata = beat_v[0] ? mem[beat_a[0]] : idle_q;
    // Commands seen at each rising edge
    always @(posedge hclk)
    begin
        idle_q <= ~idle_q;
        beat_v <= beat_v >> 1;
        for (int i = 0; i < 7; i++)
            beat_a[i] <= beat_a[i + 1];
        // Burst of four from latency on
        if (mem_cmd == SDINIT_CMD_READ && !domain_chip_select_n[0])
            for (int k = 0; k < 4; k++)
            begin
                beat_v[cas_q - 1 + k] <= 1'b1;
                beat_a[cas_q - 1 + k] <= mem_addr[7:0] + 8'(k);
            end
        if (mem_cmd == SDINIT_CMD_WRITE && mem_wdata_oe && !domain_chip_select_n[0])
            mem[mem_addr[7:0]] <= mem_wdata;
        if (mem_cmd == SDINIT_CMD_MODE_LOAD)
            cas_q <= mem_addr[6:4];
    end
endmodule

//--- bench/sdinit_top_chk.sv
// Port checker for the memory init sequencer
`timescale 1ns/1ps
module sdinit_top_chk
    import sdinit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input sdinit_cmd_t mem_cmd,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0] domain_chip_select_n,
    input wire logic mem_wdata_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take; // Address phase accepted
    logic glb_wr_q; // Global write now in data phase
    logic boot_q; // Boot domain access accepted
    assign take = hsel && htrans[1] && hready && hreadyout;
    // Remember which access was accepted
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            glb_wr_q <= 1'b0;
            boot_q <= 1'b0;
        end
        else
        begin
            glb_wr_q <= take && hwrite && haddr == {SDINIT_REG_REGION, 20'h0, SDINIT_OFF_GLOBAL};
            boot_q <= take && haddr[31:28] == SDINIT_DOM_BOOT;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_wait_bounded: assert property (!hreadyout |-> ##[1:8] hreadyout)
        else $error("wait state too long");
    a_prech_all_banks: assert property (mem_cmd == SDINIT_CMD_PRECHARGE_ALL
        |-> mem_addr[SDINIT_AP_BIT] && domain_chip_select_n == 4'h0)
        else $error("precharge not to all banks");
    a_prech_after_write: assert property (glb_wr_q && hwdata[2:0] == 3'h1
        |-> ##[1:6] mem_cmd == SDINIT_CMD_PRECHARGE_ALL)
        else $error("precharge missing");
    a_refresh_all_cs: assert property (mem_cmd == SDINIT_CMD_AUTO_REFRESH
        |-> domain_chip_select_n == 4'h0)
        else $error("refresh not to all domains");
    a_mode_one_cs: assert property (mem_cmd == SDINIT_CMD_MODE_LOAD
        |-> $onehot(~domain_chip_select_n))
        else $error("mode load chip select wrong");
    a_nop_all_cs: assert property (mem_cmd == SDINIT_CMD_NOP |-> domain_chip_select_n == 4'h0)
        else $error("nop chip select wrong");
    a_idle_deselect: assert property (mem_cmd == SDINIT_CMD_DESELECT
        |-> domain_chip_select_n == 4'hf)
        else $error("idle chip select wrong");
    a_wdata_with_write: assert property (mem_wdata_oe |-> mem_cmd == SDINIT_CMD_WRITE)
        else $error("data driven without write");
    a_boot_domain_cs: assert property (boot_q |->
        (!(mem_cmd inside {SDINIT_CMD_MODE_LOAD, SDINIT_CMD_READ})
        || domain_chip_select_n == 4'h7) [*3])
        else $error("boot access chip select wrong");
    // Main scenarios reached
    c_prech: cover property (mem_cmd == SDINIT_CMD_PRECHARGE_ALL);
    c_refresh: cover property (mem_cmd == SDINIT_CMD_AUTO_REFRESH);
    c_mode: cover property (mem_cmd == SDINIT_CMD_MODE_LOAD);
    c_write: cover property (mem_cmd == SDINIT_CMD_WRITE);
endmodule
bind sdinit_top sdinit_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .mem_cmd(mem_cmd), .mem_addr(mem_addr),
    .domain_chip_select_n(domain_chip_select_n), .mem_wdata_oe(mem_wdata_oe));

//--- bench/sdinit_top_test.sv
// Self-checking bench for the memory init sequencer
`timescale 1ns/1ps
module sdinit_top_test
    import sdinit_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, mem_wdata_oe;
    logic [31:0] hrdata, mem_wdata, mem_rdata, rd;
    sdinit_cmd_t mem_cmd;
    logic [15:0] mem_addr, pre_addr, ml_addr;
    logic [3:0] cs_n, pre_cs, ml_cs;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0, ref_n = 0, ref_last = 0, ref_gap = 0, pre_n = 0, n0;
    int ml_n = 0; // Mode loads seen
    logic [31:0] ra [7] = '{32'h8000_0000, 32'h8000_0004, 32'h8000_0008,
        32'h8000_0010, 32'h8000_0014, 32'h8000_0018, 32'h8000_001c};
    logic [31:0] ma [5] = '{32'hc000_c800, 32'hd000_6600, 32'he000_c800,
        32'hf000_c800, 32'h0000_c800};
    logic [3:0] mc [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h7};
    // Expected mode words on the address pins, CAS 3 with burst 4 or 8
    logic [12:0] mv [5] = '{13'h032, 13'h033, 13'h032, 13'h032, 13'h032};
    // Free running clock
    initial
        forever #25 hclk = ~hclk;
    sdinit_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_cmd(mem_cmd),
        .mem_addr(mem_addr), .domain_chip_select_n(cs_n), .mem_wdata(mem_wdata),
        .mem_wdata_oe(mem_wdata_oe), .mem_rdata(mem_rdata));
    sdinit_mem_model u_mem (.hclk(hclk), .mem_cmd(mem_cmd), .mem_addr(mem_addr),
        .domain_chip_select_n(cs_n), .mem_wdata(mem_wdata), .mem_wdata_oe(mem_wdata_oe),
        .mem_rdata(mem_rdata));
    // Verdict and end of run
    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Wait until ready is sampled high
    task automatic wait_rdy();
        @(negedge hclk);
        while (hreadyout !== 1'b1)
            @(negedge hclk);
        @(posedge hclk);
    endtask
    // One single word transfer
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    // Log memory commands, cut a hang short
    always @(negedge hclk)
    begin
        cyc <= cyc + 1;
        if (mem_cmd == SDINIT_CMD_AUTO_REFRESH)
        begin
            ref_n <= ref_n + 1;
            ref_gap <= cyc - ref_last;
            ref_last <= cyc;
        end
        if (mem_cmd == SDINIT_CMD_PRECHARGE_ALL)
        begin
            pre_n <= pre_n + 1;
            pre_addr <= mem_addr;
            pre_cs <= cs_n;
        end
        if (mem_cmd == SDINIT_CMD_MODE_LOAD)
        begin
            ml_n <= ml_n + 1;
            ml_addr <= mem_addr;
            ml_cs <= cs_n;
        end
        if (cyc == 8000)
        begin
            fail_count++;
            end_sim();
        end
    end
    // Init sequence then normal traffic
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        chk("cs idle", 32'hf, {28'h0, cs_n});
        chk("cmd idle", 32'h0, {29'h0, mem_cmd});
        repeat (2000) @(posedge hclk);
        foreach (ra[i])
        begin
            xfer(1'b0, ra[i], 32'h0);
            chk("reset reg", 32'h0, rd);
        end
        xfer(1'b1, 32'h8000_0014, 32'h4);
        xfer(1'b0, 32'h8000_0014, 32'h0);
        chk("width", 32'h4, rd);
        xfer(1'b1, 32'h8000_0080, 32'h7);
        xfer(1'b0, 32'h8000_0000, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b1, 32'h8000_0000, 32'h2);
        foreach (ma[i])
        begin
            n0 = ml_n;
            xfer(1'b0, ma[i], 32'h0);
            chk("mode n", 32'h1, ml_n - n0);
            chk("mode cs", {28'h0, mc[i]}, {28'h0, ml_cs});
            chk("mode ad", {19'h0, mv[i]}, {19'h0, ml_addr[12:0]});
        end
        xfer(1'b1, 32'h8000_0000, 32'h3);
        repeat (3) @(negedge hclk);
        chk("nop cmd", {29'h0, SDINIT_CMD_NOP}, {29'h0, mem_cmd});
        repeat (4000) @(posedge hclk);
        xfer(1'b1, 32'h8000_0000, 32'h1);
        repeat (3) @(negedge hclk);
        chk("prech n", 32'h1, pre_n);
        chk("prech ap", 32'h1, {31'h0, pre_addr[SDINIT_AP_BIT]});
        chk("prech cs", 32'h0, {28'h0, pre_cs});
        @(posedge hclk);
        xfer(1'b1, 32'h8000_0004, 32'hb);
        n0 = ref_n;
        repeat (85) @(negedge hclk);
        chk("ref count", 32'h1, 32'(ref_n - n0 >= 8));
        chk("ref gap", 32'ha, ref_gap);
        @(posedge hclk);
        xfer(1'b1, 32'h8000_0004, 32'h40);
        xfer(1'b1, 32'h8000_0000, 32'h2);
        repeat (150) @(negedge hclk);
        chk("ref gap", 32'h3f, ref_gap);
        @(posedge hclk);
        // Second mode load with refresh running
        n0 = ml_n;
        xfer(1'b0, 32'hc000_c800, 32'h0);
        chk("mode again", 32'h1, ml_n - n0);
        chk("mode cs again", 32'he, {28'h0, ml_cs});
        chk("mode ad again", 32'h32, {19'h0, ml_addr[12:0]});
        xfer(1'b1, 32'h8000_0010, 32'h30);
        xfer(1'b1, 32'h8000_0000, 32'h0);
        xfer(1'b1, 32'hc000_0010, 32'h5a3c_0f96);
        xfer(1'b0, 32'hc000_0010, 32'h0);
        chk("mem read", 32'h5a3c_0f96, rd);
        end_sim();
    end
endmodule

//--- hdl/sdinit_pkg.sv
// Constants, offsets and types shared by the memory init sequencer files
package sdinit_pkg;

    // Register region selected by haddr[31:28]
    localparam logic [3:0] SDINIT_REG_REGION = 4'h8;
    // Register byte offsets within the region
    localparam logic [7:0] SDINIT_OFF_GLOBAL = 8'h00;
    localparam logic [7:0] SDINIT_OFF_REFRESH = 8'h04;
    localparam logic [7:0] SDINIT_OFF_STATUS = 8'h08;
    localparam logic [3:0] SDINIT_OFF_DOMAIN_HI = 4'h1;
    // Global control bit positions
    localparam int SDINIT_GLB_INIT_BIT = 0;
    localparam int SDINIT_GLB_MODE_LOAD_ACCESS_BIT = 1;
    localparam int SDINIT_GLB_COMMAND_REG_LOAD_BIT = 2;
    // Domain config fields
    localparam int SDINIT_DCFG_WIDTH_BIT = 2;
    localparam int SDINIT_DCFG_CAS_LSB = 4;
    // Status bit positions
    localparam int SDINIT_STAT_ARMED_BIT = 0;
    localparam int SDINIT_STAT_PRECH_BIT = 1;
    localparam int SDINIT_STAT_REFRESH_BIT = 2;
    // Values after reset
    localparam logic [31:0] SDINIT_GLB_RESET = 32'h0000_0000;
    localparam logic [15:0] SDINIT_REFRESH_RESET = 16'h0000;
    localparam logic [31:0] SDINIT_DCFG_RESET = 32'h0000_0000;
    // Memory domain nibbles of haddr[31:28]
    localparam logic [3:0] SDINIT_DOM_FIRST = 4'hc;
    localparam logic [3:0] SDINIT_DOM_BOOT = 4'h0;
    localparam logic [1:0] SDINIT_DOM_BOOT_CS = 2'h3;
    // Refresh count: interval in cycles is count minus one
    localparam logic [15:0] SDINIT_REFCNT_MIN = 16'h0002;
    // Precharge-all flag on the address pins
    localparam int SDINIT_AP_BIT = 10;
    // Shortest and longest CAS latency the controller handles
    localparam logic [1:0] SDINIT_CAS_MIN = 2'h2;
    localparam logic [1:0] SDINIT_CAS_MAX = 2'h3;

    // Command placed on the memory bus each cycle
    typedef enum logic [2:0] {
        SDINIT_CMD_DESELECT,
        SDINIT_CMD_NOP,
        SDINIT_CMD_PRECHARGE_ALL,
        SDINIT_CMD_AUTO_REFRESH,
        SDINIT_CMD_MODE_LOAD,
        SDINIT_CMD_READ,
        SDINIT_CMD_WRITE
    } sdinit_cmd_t;

    // Operating setting decoded from global control
    typedef enum logic [2:0] {
        SDINIT_OP_NORMAL,
        SDINIT_OP_MODE_ACCESS,
        SDINIT_OP_NOP_STREAM,
        SDINIT_OP_PRECHARGE,
        SDINIT_OP_OTHER
    } sdinit_op_t;

    // Bus transfer sequencer states
    typedef enum logic [1:0] {
        SDINIT_ST_IDLE,
        SDINIT_ST_ACCESS,
        SDINIT_ST_CAS,
        SDINIT_ST_DONE
    } sdinit_state_t;

endpackage

//--- hdl/sdinit_refresh_timer.sv
// Auto-refresh interval timer of the memory init sequencer
`timescale 1ns/1ps
module sdinit_refresh_timer
    import sdinit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic [15:0] refcnt,
    output logic tick
);
    // Whole timer state
    typedef struct packed {
        logic run;
        logic [15:0] count;
    } sdinit_tmr_state_t;

    sdinit_tmr_state_t q, d;

    // Tick when the down counter expires
    assign tick = enable && q.run && (q.count == 16'h0000);

    // Reload with count minus two, so period is count minus one cycles
    always_comb
    begin
        d = q;
        if (!enable)
        begin
            // Stopped: restart cleanly when enabled again
            d.run = 1'b0;
            d.count = 16'h0000;
        end
        else if (!q.run || (q.count == 16'h0000))
        begin
            d.run = 1'b1;
            d.count = refcnt - SDINIT_REFCNT_MIN; // [R9]
        end
        else
        begin
            d.count = q.count - 16'h0001;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end
endmodule

//--- hdl/sdinit_top.sv
// Memory init sequencer: AHB-Lite slave, domain decode and command issue
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1: Width bit one means 16-bit bus
// R2: Software waits 100 us after power-on
// R3: Software sets width before mode reads
// R4: Mode access turns reads into mode loads
// R5: First mode read uses address 0x2/0x3
// R6: Init with mode access streams NOPs
// R7: Software holds NOP stream 200 us
// R8: Init alone issues one precharge-all
// R9: Count 0xB refreshes every 10 cycles
// R10: Software waits 80 cycles for refreshes
// R11: Software then writes normal refresh count
// R12: Software reads each domain for mode
// R13: Software copies mode values into configs
// R14: All three bits clear means normal operation
// R15: Address 31:28 selects chip select domain
// R16: Loaded CAS latency must be 2 or 3
// R17: Mode read completes, data is don't-care
// R18: Refresh keeps running after precharge
module sdinit_top
    import sdinit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output sdinit_cmd_t mem_cmd,
    output logic [15:0] mem_addr,
    output logic [3:0] domain_chip_select_n,
    output logic [31:0] mem_wdata,
    output logic mem_wdata_oe,
    input wire logic [31:0] mem_rdata
);
    // Whole block state
    typedef struct packed {
        sdinit_state_t state;     // Transfer sequencer
        logic [31:0] addr;        // Captured address
        logic write;              // Captured direction
        logic is_reg;             // Register region hit
        logic is_mem;             // Memory domain hit
        logic [1:0] dom;          // Selected chip select
        logic [31:0] glb;         // Global memory control
        logic [15:0] refcnt;      // Refresh timer control
        logic [3:0][31:0] dcfg;   // Domain device configs
        logic prech_pend;         // Precharge-all waiting
        logic refresh_pend;       // Auto-refresh waiting
        logic armed;              // Precharge done, refresh allowed
        logic [1:0] cas_cnt;      // Read latency counter
        logic [31:0] rdata;       // Read data to bus
        sdinit_cmd_t cmd;         // Memory command
        logic [15:0] ad;          // Memory address pins
        logic [3:0] cs_n;         // Chip selects
        logic [31:0] wdata;       // Memory write data
        logic wdata_oe;           // Memory data drive
    } sdinit_top_state_t;

    sdinit_top_state_t q, d;
    sdinit_op_t op;               // Current operating setting
    logic refresh_tick;           // Interval expired
    logic refresh_en;             // Timer running

    // Decode of the three global control bits
    always_comb
    begin
        op = SDINIT_OP_OTHER;
        if (q.glb[SDINIT_GLB_COMMAND_REG_LOAD_BIT])
        begin
            op = SDINIT_OP_OTHER;
        end
        else if (!q.glb[SDINIT_GLB_INIT_BIT] && !q.glb[SDINIT_GLB_MODE_LOAD_ACCESS_BIT])
        begin
            op = SDINIT_OP_NORMAL; // [R14]
        end
        else if (!q.glb[SDINIT_GLB_INIT_BIT])
        begin
            op = SDINIT_OP_MODE_ACCESS; // [R4]
        end
        else if (q.glb[SDINIT_GLB_MODE_LOAD_ACCESS_BIT])
        begin
            op = SDINIT_OP_NOP_STREAM; // [R6]
        end
        else
        begin
            op = SDINIT_OP_PRECHARGE; // [R8]
        end
    end

    // Refresh runs in every setting once precharge has gone out
    assign refresh_en = q.armed && (q.refcnt >= SDINIT_REFCNT_MIN); // [R18]

    sdinit_refresh_timer u_refresh_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .enable(refresh_en),
        .refcnt(q.refcnt),
        .tick(refresh_tick)
    );

    // Bus outputs
    assign hreadyout = (q.state == SDINIT_ST_IDLE) || (q.state == SDINIT_ST_DONE);
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign mem_cmd = q.cmd;
    assign mem_addr = q.ad;
    assign domain_chip_select_n = q.cs_n;
    assign mem_wdata = q.wdata;
    assign mem_wdata_oe = q.wdata_oe;

    // Next state of the whole block
    always_comb
    begin
        logic busy;
        logic w16;
        logic [3:0] nib;
        logic [7:0] off;
        logic [1:0] cas;
        busy = 1'b0;
        w16 = q.dcfg[q.dom][SDINIT_DCFG_WIDTH_BIT];
        nib = haddr[31:28];
        off = q.addr[7:0];
        cas = q.dcfg[q.dom][SDINIT_DCFG_CAS_LSB +: 2];
        d = q;
        // Bus idles deselected unless something drives it
        d.cmd = SDINIT_CMD_DESELECT;
        d.cs_n = 4'hf;
        d.ad = 16'h0000;
        d.wdata_oe = 1'b0;
        if (op == SDINIT_OP_NOP_STREAM)
        begin
            // Continuous NOP to every domain
            d.cmd = SDINIT_CMD_NOP; // [R6]
            d.cs_n = 4'h0;
        end
        // Housekeeping commands take the bus first
        if (q.prech_pend)
        begin
            d.cmd = SDINIT_CMD_PRECHARGE_ALL; // [R8]
            d.cs_n = 4'h0;
            d.ad[SDINIT_AP_BIT] = 1'b1;
            d.prech_pend = 1'b0;
            d.armed = 1'b1;
            busy = 1'b1;
        end
        else if (q.refresh_pend)
        begin
            d.cmd = SDINIT_CMD_AUTO_REFRESH; // [R9]
            d.cs_n = 4'h0;
            d.refresh_pend = 1'b0;
            busy = 1'b1;
        end
        case (q.state)
            SDINIT_ST_CAS:
            begin
                // Wait out CAS latency, then take the data
                if (q.cas_cnt == 2'h0)
                begin
                    d.rdata = mem_rdata;
                    d.state = SDINIT_ST_DONE;
                end
                else
                begin
                    d.cas_cnt = q.cas_cnt - 2'h1;
                end
            end
            SDINIT_ST_ACCESS:
            begin
                if (q.is_reg)
                begin
                    d.rdata = 32'h0000_0000;
                    d.state = SDINIT_ST_DONE;
                    if (q.write)
                    begin
                        // Register writes, address decode
                        if (off == SDINIT_OFF_GLOBAL)
                        begin
                            d.glb = hwdata;
                            if (hwdata[SDINIT_GLB_INIT_BIT] &&
                                !hwdata[SDINIT_GLB_MODE_LOAD_ACCESS_BIT] &&
                                !hwdata[SDINIT_GLB_COMMAND_REG_LOAD_BIT])
                            begin
                                d.prech_pend = 1'b1; // [R8]
                            end
                        end
                        else if (off == SDINIT_OFF_REFRESH)
                        begin
                            d.refcnt = hwdata[15:0]; // [R9]
                        end
                        else if (off[7:4] == SDINIT_OFF_DOMAIN_HI)
                        begin
                            d.dcfg[off[3:2]] = hwdata; // [R1]
                        end
                    end
                    else
                    begin
                        // Register reads; unmapped reads as zero
                        if (off == SDINIT_OFF_GLOBAL)
                        begin
                            d.rdata = q.glb;
                        end
                        else if (off == SDINIT_OFF_REFRESH)
                        begin
                            d.rdata = {16'h0000, q.refcnt};
                        end
                        else if (off == SDINIT_OFF_STATUS)
                        begin
                            d.rdata[SDINIT_STAT_ARMED_BIT] = q.armed;
                            d.rdata[SDINIT_STAT_PRECH_BIT] = q.prech_pend;
                            d.rdata[SDINIT_STAT_REFRESH_BIT] = q.refresh_pend;
                        end
                        else if (off[7:4] == SDINIT_OFF_DOMAIN_HI)
                        begin
                            d.rdata = q.dcfg[off[3:2]];
                        end
                    end
                end
                else if (q.is_mem && (op == SDINIT_OP_MODE_ACCESS) && !q.write)
                begin
                    // Read address becomes the mode value
                    if (!busy)
                    begin
                        d.cmd = SDINIT_CMD_MODE_LOAD; // [R4]
                        d.cs_n = ~(4'h1 << q.dom);
                        d.ad[12:0] = w16 ? q.addr[21:9] : q.addr[22:10]; // [R1]
                        d.rdata = 32'h0000_0000; // [R17]
                        d.state = SDINIT_ST_DONE;
                    end
                end
                else if (q.is_mem && (op == SDINIT_OP_NORMAL))
                begin
                    // Plain column access in normal operation
                    if (!busy)
                    begin
                        d.cs_n = ~(4'h1 << q.dom);
                        d.ad = w16 ? q.addr[16:1] : q.addr[17:2]; // [R1]
                        if (q.write)
                        begin
                            d.cmd = SDINIT_CMD_WRITE;
                            d.wdata = hwdata;
                            d.wdata_oe = 1'b1;
                            d.state = SDINIT_ST_DONE;
                        end
                        else
                        begin
                            d.cmd = SDINIT_CMD_READ;
                            // Latencies other than 2 or 3 treated as 3
                            d.cas_cnt = (cas == SDINIT_CAS_MIN) ? SDINIT_CAS_MIN
                                                                 : SDINIT_CAS_MAX;
                            d.state = SDINIT_ST_CAS;
                        end
                    end
                end
                else
                begin
                    // Unmapped, or memory access not allowed now
                    d.rdata = 32'h0000_0000;
                    d.state = SDINIT_ST_DONE;
                end
            end
            default:
            begin
                d.state = SDINIT_ST_IDLE;
            end
        endcase
        // New address phase taken when hready is high
        if (((q.state == SDINIT_ST_IDLE) || (q.state == SDINIT_ST_DONE)) &&
            hsel && htrans[1] && hready)
        begin
            d.state = SDINIT_ST_ACCESS;
            d.addr = haddr;
            d.write = hwrite;
            d.is_reg = (nib == SDINIT_REG_REGION);
            d.is_mem = (nib >= SDINIT_DOM_FIRST) || (nib == SDINIT_DOM_BOOT); // [R15]
            d.dom = (nib == SDINIT_DOM_BOOT) ? SDINIT_DOM_BOOT_CS : nib[1:0]; // [R15]
        end
        // A new interval tick wins over the clear
        if (refresh_tick)
        begin
            d.refresh_pend = 1'b1; // [R18]
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.glb <= SDINIT_GLB_RESET;
            q.refcnt <= SDINIT_REFRESH_RESET;
            q.dcfg <= {4{SDINIT_DCFG_RESET}};
            q.cs_n <= 4'hf;
        end
        else if (ce)
        begin
            q <= d;
        end
    end
endmodule
